// ---- verilog/pin_mux_pkg.sv ----
// Shared widths, pin-function codes, routing table and reset values for the pin mux
package pin_mux_pkg;

  // Pins per port and flat pin index base of each port
  localparam int unsigned PORT_A_PINS = 8;
  localparam int unsigned PORT_B_PINS = 8;
  localparam int unsigned PORT_C_PINS = 6;
  localparam int unsigned PORT_D_PINS = 4;
  localparam int unsigned PORT_A_BASE = 0;
  localparam int unsigned PORT_B_BASE = PORT_A_BASE + PORT_A_PINS;
  localparam int unsigned PORT_C_BASE = PORT_B_BASE + PORT_B_PINS;
  localparam int unsigned PORT_D_BASE = PORT_C_BASE + PORT_C_PINS;
  localparam int unsigned NUM_PINS    = PORT_D_BASE + PORT_D_PINS;
  localparam int unsigned PIN_IDX_W   = 5;
  localparam int unsigned SEL_W       = 2;
  localparam int unsigned SLOTS       = 4;
  localparam int unsigned FN_W        = 6;
  localparam int unsigned NUM_FUNCS   = 41;

  // Peripheral function codes
  localparam logic [FN_W-1:0] FN_PWM_OUT_0            = 6'h00;
  localparam logic [FN_W-1:0] FN_PWM_OUT_1            = 6'h01;
  localparam logic [FN_W-1:0] FN_PWM_OUT_2            = 6'h02;
  localparam logic [FN_W-1:0] FN_PWM_OUT_3            = 6'h03;
  localparam logic [FN_W-1:0] FN_PWM_OUT_4            = 6'h04;
  localparam logic [FN_W-1:0] FN_PWM_OUT_5            = 6'h05;
  localparam logic [FN_W-1:0] FN_TIMER_CH_0           = 6'h06;
  localparam logic [FN_W-1:0] FN_TIMER_CH_1           = 6'h07;
  localparam logic [FN_W-1:0] FN_TIMER_CH_2           = 6'h08;
  localparam logic [FN_W-1:0] FN_TIMER_CH_3           = 6'h09;
  localparam logic [FN_W-1:0] FN_FAULT_IN_0           = 6'h0A;
  localparam logic [FN_W-1:0] FN_FAULT_IN_1           = 6'h0B;
  localparam logic [FN_W-1:0] FN_FAULT_IN_2           = 6'h0C;
  localparam logic [FN_W-1:0] FN_FAULT_IN_3           = 6'h0D;
  localparam logic [FN_W-1:0] FN_RESET_IN             = 6'h0E;
  localparam logic [FN_W-1:0] FN_SPI_CLOCK            = 6'h0F;
  localparam logic [FN_W-1:0] FN_SPI_SLAVE_SEL        = 6'h10;
  localparam logic [FN_W-1:0] FN_SPI_MISO             = 6'h11;
  localparam logic [FN_W-1:0] FN_SPI_MOSI             = 6'h12;
  localparam logic [FN_W-1:0] FN_I2C_SCL              = 6'h13;
  localparam logic [FN_W-1:0] FN_I2C_SDA              = 6'h14;
  localparam logic [FN_W-1:0] FN_PWM_RELOAD_SRC_0     = 6'h15;
  localparam logic [FN_W-1:0] FN_PWM_RELOAD_SRC_1     = 6'h16;
  localparam logic [FN_W-1:0] FN_PWM_RELOAD_SRC_2     = 6'h17;
  localparam logic [FN_W-1:0] FN_CLOCK_OUTPUT         = 6'h18;
  localparam logic [FN_W-1:0] FN_EXTERNAL_CLOCK_INPUT = 6'h19;
  localparam logic [FN_W-1:0] FN_SERIAL_RECEIVE_DATA_0  = 6'h1A;
  localparam logic [FN_W-1:0] FN_SERIAL_TRANSMIT_DATA_0 = 6'h1B;
  localparam logic [FN_W-1:0] FN_ANALOG_INPUT_A0      = 6'h1C;
  localparam logic [FN_W-1:0] FN_ANALOG_INPUT_A1      = 6'h1D;
  localparam logic [FN_W-1:0] FN_ANALOG_INPUT_A2      = 6'h1E;
  localparam logic [FN_W-1:0] FN_CONVERTER_A_HIGH_REF = 6'h1F;
  localparam logic [FN_W-1:0] FN_ANALOG_INPUT_B0      = 6'h20;
  localparam logic [FN_W-1:0] FN_COMPARATOR_B_INPUT_3 = 6'h21;
  localparam logic [FN_W-1:0] FN_ANALOG_INPUT_B1      = 6'h22;
  localparam logic [FN_W-1:0] FN_ANALOG_INPUT_B2      = 6'h23;
  localparam logic [FN_W-1:0] FN_CONVERTER_B_HIGH_REF = 6'h24;
  localparam logic [FN_W-1:0] FN_JTAG_TDI             = 6'h25;
  localparam logic [FN_W-1:0] FN_JTAG_TDO             = 6'h26;
  localparam logic [FN_W-1:0] FN_JTAG_TCK             = 6'h27;
  localparam logic [FN_W-1:0] FN_JTAG_TMS             = 6'h28;
  localparam logic [FN_W-1:0] FN_NONE                 = 6'h3F;

  // Idle level seen by a peripheral input that no pin feeds
  localparam logic [NUM_FUNCS-1:0] FN_IDLE =
    (41'h1 << FN_RESET_IN) | (41'h1 << FN_SPI_SLAVE_SEL) | (41'h1 << FN_I2C_SCL) |
    (41'h1 << FN_I2C_SDA) | (41'h1 << FN_SERIAL_RECEIVE_DATA_0) | (41'h1 << FN_JTAG_TMS);

  // Pin function per select code; unused codes leave the pin unrouted
  localparam logic [FN_W-1:0] PIN_FUNC [NUM_PINS][SLOTS] = '{
    '{FN_PWM_OUT_0, FN_NONE, FN_NONE, FN_NONE},
    '{FN_PWM_OUT_1, FN_NONE, FN_NONE, FN_NONE},
    '{FN_PWM_OUT_2, FN_NONE, FN_NONE, FN_NONE},
    '{FN_PWM_OUT_3, FN_NONE, FN_NONE, FN_NONE},
    '{FN_PWM_OUT_4, FN_TIMER_CH_2, FN_FAULT_IN_1, FN_NONE},
    '{FN_PWM_OUT_5, FN_TIMER_CH_3, FN_FAULT_IN_2, FN_NONE},
    '{FN_FAULT_IN_0, FN_TIMER_CH_0, FN_NONE, FN_NONE},
    '{FN_RESET_IN, FN_NONE, FN_NONE, FN_NONE},
    '{FN_SPI_CLOCK, FN_I2C_SCL, FN_NONE, FN_NONE},
    '{FN_SPI_SLAVE_SEL, FN_I2C_SDA, FN_NONE, FN_NONE},
    '{FN_SPI_MISO, FN_TIMER_CH_2, FN_PWM_RELOAD_SRC_0, FN_NONE},
    '{FN_SPI_MOSI, FN_TIMER_CH_3, FN_PWM_RELOAD_SRC_1, FN_NONE},
    '{FN_TIMER_CH_0, FN_CLOCK_OUTPUT, FN_PWM_RELOAD_SRC_2, FN_NONE},
    '{FN_TIMER_CH_1, FN_FAULT_IN_3, FN_EXTERNAL_CLOCK_INPUT, FN_NONE},
    '{FN_SERIAL_RECEIVE_DATA_0, FN_I2C_SDA, FN_EXTERNAL_CLOCK_INPUT, FN_NONE},
    '{FN_SERIAL_TRANSMIT_DATA_0, FN_I2C_SCL, FN_NONE, FN_NONE},
    '{FN_ANALOG_INPUT_A0, FN_NONE, FN_NONE, FN_NONE},
    '{FN_ANALOG_INPUT_A1, FN_NONE, FN_NONE, FN_NONE},
    '{FN_ANALOG_INPUT_A2, FN_CONVERTER_A_HIGH_REF, FN_NONE, FN_NONE},
    '{FN_ANALOG_INPUT_B0, FN_COMPARATOR_B_INPUT_3, FN_NONE, FN_NONE},
    '{FN_ANALOG_INPUT_B1, FN_NONE, FN_NONE, FN_NONE},
    '{FN_ANALOG_INPUT_B2, FN_CONVERTER_B_HIGH_REF, FN_NONE, FN_NONE},
    '{FN_JTAG_TDI, FN_NONE, FN_NONE, FN_NONE},
    '{FN_JTAG_TDO, FN_NONE, FN_NONE, FN_NONE},
    '{FN_JTAG_TCK, FN_NONE, FN_NONE, FN_NONE},
    '{FN_JTAG_TMS, FN_NONE, FN_NONE, FN_NONE}
  };

  // Reset mode: port A pin 7 and all of port D start on their peripheral
  localparam logic [NUM_PINS-1:0] MODE_RST = 26'h3C00080;
  localparam logic [SEL_W-1:0]    SEL_RST  = 2'h0;

endpackage : pin_mux_pkg

// ---- verilog/pin_cfg_reg.sv ----
// Per-pin mode bits and the peripheral select register
module pin_cfg_reg #(
  parameter int unsigned DEPTH = pin_mux_pkg::NUM_PINS
) (
  input  wire logic                                 clock_i,
  input  wire logic                                 srst_i,
  input  wire logic                                 ce_i,
  input  wire logic                                 wr_i,
  input  wire logic [pin_mux_pkg::PIN_IDX_W-1:0]    wr_pin_i,
  input  wire logic                                 wr_periph_i,
  input  wire logic [pin_mux_pkg::SEL_W-1:0]        wr_sel_i,
  output logic      [DEPTH-1:0]                     mode_o,
  output logic      [pin_mux_pkg::SEL_W*DEPTH-1:0]  sel_o
);

  logic [DEPTH-1:0]                    hit;
  logic [DEPTH-1:0]                    mode_d;
  logic [DEPTH-1:0]                    mode_q;
  logic [pin_mux_pkg::SEL_W*DEPTH-1:0] sel_d;
  logic [pin_mux_pkg::SEL_W*DEPTH-1:0] sel_q;

  // Entry decode and update; an index past the last pin writes nothing
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    assign hit[i] = wr_i && (wr_pin_i == pin_mux_pkg::PIN_IDX_W'(i));
    assign mode_d[i] = hit[i] ? wr_periph_i : mode_q[i];
    assign sel_d[pin_mux_pkg::SEL_W*i +: pin_mux_pkg::SEL_W] =
      hit[i] ? wr_sel_i : sel_q[pin_mux_pkg::SEL_W*i +: pin_mux_pkg::SEL_W];
  end

  // Reset wins over a low clock enable
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_q <= pin_mux_pkg::MODE_RST;
      sel_q  <= {DEPTH{pin_mux_pkg::SEL_RST}};
    end else if (ce_i) begin
      mode_q <= mode_d;
      sel_q  <= sel_d;
    end
  end

  assign mode_o = mode_q;
  assign sel_o  = sel_q;

endmodule : pin_cfg_reg

// ---- verilog/pad_cell.sv ----
// Output level and enable flops for one package pin
module pad_cell (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic ce_i,
  input  wire logic periph_mode_i,
  input  wire logic routed_i,
  input  wire logic gpio_do_i,
  input  wire logic gpio_dir_i,
  input  wire logic periph_do_i,
  input  wire logic periph_oe_i,
  output logic      pad_do_o,
  output logic      pad_oe_n_o
);

  logic pad_do_d;
  logic pad_do_q;
  logic pad_oe_n_d;
  logic pad_oe_n_q;

  // Port bits own the pin in port mode; peripheral enables are not looked at
  always_comb begin
    if (!periph_mode_i) begin
      pad_do_d   = gpio_do_i;
      pad_oe_n_d = !gpio_dir_i;
    end else if (routed_i) begin
      pad_do_d   = periph_do_i;
      pad_oe_n_d = !periph_oe_i;
    end else begin
      pad_do_d   = 1'b0;
      pad_oe_n_d = 1'b1;
    end
  end

  // Pin floats during reset so nothing fights the board
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pad_do_q   <= 1'b0;
      pad_oe_n_q <= 1'b1;
    end else if (ce_i) begin
      pad_do_q   <= pad_do_d;
      pad_oe_n_q <= pad_oe_n_d;
    end
  end

  assign pad_do_o   = pad_do_q;
  assign pad_oe_n_o = pad_oe_n_q;

endmodule : pad_cell

// ---- verilog/gpio_port_pin_mux.sv ----
// Pin multiplexer between port bits and peripheral signals for ports A to D
//
// Contract
// - Four ports: A and B have eight pins, C six, D four.
// - A5 resets to port use; peripheral choices pwm 5, timer 3, fault 2.
// - A6 resets to port use; peripheral choices fault 0 or timer 0.
// - Port A carries pwm, timer, fault; A7 resets as reset input.
// - B0 resets to port use; peripheral choices spi clock or i2c clock.
// - B2 resets to port use; choices spi miso, timer 2, reload source 0.
// - B3 resets to port use; choices spi mosi, timer 3, reload source 1.
// - B4 resets to port use; choices timer 0, clock output, reload source 2.
// - B5 resets to port use; choices timer 1, fault 3, external clock.
// - External clock reaches the clock generator only when its enable is set.
// - B6 resets to port use; choices serial receive, i2c data, external clock.
// - B7 resets to port use; choices serial transmit or i2c clock.
// - C2 resets to port use; choices analog A2 or converter A reference.
// - C4 resets to port use; choices analog B0 or comparator B input 3.
// - C6 resets to port use; choices analog B2 or converter B reference.
// - Port D pins reset to the four JTAG signals.
module gpio_port_pin_mux (
  input  wire logic                                    clock_i,
  input  wire logic                                    srst_i,
  input  wire logic                                    ce_i,
  input  wire logic                                    cfg_wr_i,
  input  wire logic [pin_mux_pkg::PIN_IDX_W-1:0]       cfg_pin_i,
  input  wire logic                                    cfg_periph_i,
  input  wire logic [pin_mux_pkg::SEL_W-1:0]           cfg_sel_i,
  input  wire logic                                    pll_ext_clk_en_i,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]        gpio_do_i,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]        gpio_dir_i,
  input  wire logic [pin_mux_pkg::NUM_FUNCS-1:0]       periph_do_i,
  input  wire logic [pin_mux_pkg::NUM_FUNCS-1:0]       periph_oe_i,
  input  wire logic [pin_mux_pkg::NUM_PINS-1:0]        pad_in_i,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]        pad_do_o,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]        pad_oe_n_o,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]        gpio_di_o,
  output logic      [pin_mux_pkg::NUM_FUNCS-1:0]       periph_di_o,
  output logic      [pin_mux_pkg::NUM_PINS-1:0]        periph_mode_o,
  output logic      [2*pin_mux_pkg::NUM_PINS-1:0]      peripheral_select_reg_o
);

  logic [pin_mux_pkg::NUM_PINS-1:0]  mode;
  logic [2*pin_mux_pkg::NUM_PINS-1:0] sel;
  logic [pin_mux_pkg::FN_W-1:0]      pin_fn [pin_mux_pkg::NUM_PINS];
  logic [pin_mux_pkg::NUM_PINS-1:0]  routed;
  logic [pin_mux_pkg::NUM_PINS-1:0]  pin_pdo;
  logic [pin_mux_pkg::NUM_PINS-1:0]  pin_poe;
  logic [pin_mux_pkg::NUM_FUNCS-1:0] periph_di_d;
  logic [pin_mux_pkg::NUM_FUNCS-1:0] periph_di_q;
  logic [pin_mux_pkg::NUM_PINS-1:0]  gpio_di_d;
  logic [pin_mux_pkg::NUM_PINS-1:0]  gpio_di_q;

  // Mode bits and select codes; reset defaults live in the package
  pin_cfg_reg #(
    .DEPTH       (pin_mux_pkg::NUM_PINS)
  ) u_cfg (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .wr_i        (cfg_wr_i),
    .wr_pin_i    (cfg_pin_i),
    .wr_periph_i (cfg_periph_i),
    .wr_sel_i    (cfg_sel_i),
    .mode_o      (mode),
    .sel_o       (sel)
  );

  // Per-pin function lookup and output cell across all four ports
  for (genvar p = 0; p < pin_mux_pkg::NUM_PINS; p++) begin : g_pin
    assign pin_fn[p] = pin_mux_pkg::PIN_FUNC[p][sel[2*p +: 2]];
    // A spare select code leaves the pin unrouted rather than guessing a function
    assign routed[p] = mode[p] && (pin_fn[p] < pin_mux_pkg::NUM_FUNCS);
    assign pin_pdo[p] = routed[p] ? periph_do_i[pin_fn[p]] : 1'b0;
    assign pin_poe[p] = routed[p] ? periph_oe_i[pin_fn[p]] : 1'b0;

    pad_cell u_pad (
      .clock_i       (clock_i),
      .srst_i        (srst_i),
      .ce_i          (ce_i),
      .periph_mode_i (mode[p]),
      .routed_i      (routed[p]),
      .gpio_do_i     (gpio_do_i[p]),
      .gpio_dir_i    (gpio_dir_i[p]),
      .periph_do_i   (pin_pdo[p]),
      .periph_oe_i   (pin_poe[p]),
      .pad_do_o      (pad_do_o[p]),
      .pad_oe_n_o    (pad_oe_n_o[p])
    );
  end

  // Peripheral input routing; the lowest pin wins when two feed one input
  always_comb begin
    periph_di_d = pin_mux_pkg::FN_IDLE;
    for (int p = pin_mux_pkg::NUM_PINS - 1; p >= 0; p--) begin
      if (routed[p]) begin
        periph_di_d[pin_fn[p]] = pad_in_i[p];
      end
    end
    // Pin choice alone never clocks the device
    if (!pll_ext_clk_en_i) begin
      periph_di_d[pin_mux_pkg::FN_EXTERNAL_CLOCK_INPUT] =
        pin_mux_pkg::FN_IDLE[pin_mux_pkg::FN_EXTERNAL_CLOCK_INPUT];
    end
    gpio_di_d = pad_in_i;
  end

  // Input sample flops; reset shows idle levels so no peripheral sees a glitch
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      periph_di_q <= pin_mux_pkg::FN_IDLE;
      gpio_di_q   <= '0;
    end else if (ce_i) begin
      periph_di_q <= periph_di_d;
      gpio_di_q   <= gpio_di_d;
    end
  end

  assign periph_di_o             = periph_di_q;
  assign gpio_di_o               = gpio_di_q;
  assign periph_mode_o           = mode;
  assign peripheral_select_reg_o = sel;

  // Reset defaults
  a_rst_jtag_dflt: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(srst_i) |-> (periph_mode_o[25:22] == 4'hF) && (pad_oe_n_o[25:22] == 4'hF))
    else $error("port D not on jtag after reset");

  a_rst_reset_pin: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(srst_i) |-> periph_mode_o[7] && periph_di_o[pin_mux_pkg::FN_RESET_IN])
    else $error("reset pin not on reset function after reset");

  a_rst_gpio_dflt: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(srst_i) |-> ((periph_mode_o & ~pin_mux_pkg::MODE_RST) == '0)
                      && (peripheral_select_reg_o == '0))
    else $error("port pins not in port mode after reset");

  // Port mode path and hold with clock enable low
  a_gpio_oe_ignore: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) |->
      (((pad_oe_n_o ^ ~$past(gpio_dir_i)) & ~$past(periph_mode_o)) == '0))
    else $error("port mode enable not from direction bit");

  a_gpio_data_path: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) |->
      (((pad_do_o ^ $past(gpio_do_i)) & ~$past(periph_mode_o)) == '0))
    else $error("port mode level not from data bit");

  a_freeze_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    !ce_i ##1 !srst_i |-> $stable(pad_do_o) && $stable(pad_oe_n_o) && $stable(periph_di_o))
    else $error("state moved with clock enable low");

  // External clock gate
  a_extclk_gate: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && !$past(pll_ext_clk_en_i) |->
      periph_di_o[pin_mux_pkg::FN_EXTERNAL_CLOCK_INPUT] ==
      pin_mux_pkg::FN_IDLE[pin_mux_pkg::FN_EXTERNAL_CLOCK_INPUT])
    else $error("external clock passed while disabled");

  // Idle level on unfed inputs and float on an unrouted pin
  a_fault_in_1_idle: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && !($past(periph_mode_o[4]) && $past(sel[9:8]) == 2'h2) |->
      periph_di_o[pin_mux_pkg::FN_FAULT_IN_1] == pin_mux_pkg::FN_IDLE[pin_mux_pkg::FN_FAULT_IN_1])
    else $error("unrouted fault input not idle");

  a_unrouted_float: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[8]) && $past(sel[17:16]) == 2'h3 |->
      pad_oe_n_o[8] && !pad_do_o[8])
    else $error("unrouted pin is driven");

  // Input routes
  a_a4_fault_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[4]) && $past(sel[9:8]) == 2'h2 |->
      periph_di_o[pin_mux_pkg::FN_FAULT_IN_1] == $past(pad_in_i[4]))
    else $error("A4 fault route wrong");

  a_a5_fault_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[5]) && $past(sel[11:10]) == 2'h2 |->
      periph_di_o[pin_mux_pkg::FN_FAULT_IN_2] == $past(pad_in_i[5]))
    else $error("A5 fault route wrong");

  a_a6_timer_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[6]) && $past(sel[13:12]) == 2'h1 |->
      periph_di_o[pin_mux_pkg::FN_TIMER_CH_0] == $past(pad_in_i[6]))
    else $error("A6 timer route wrong");

  a_b5_fault_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[13]) && $past(sel[27:26]) == 2'h1 |->
      periph_di_o[pin_mux_pkg::FN_FAULT_IN_3] == $past(pad_in_i[13]))
    else $error("B5 fault route wrong");

  a_b6_rx_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[14]) && $past(sel[29:28]) == 2'h0 |->
      periph_di_o[pin_mux_pkg::FN_SERIAL_RECEIVE_DATA_0] == $past(pad_in_i[14]))
    else $error("B6 receive route wrong");

  a_c2_vref_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[18]) && $past(sel[37:36]) == 2'h1 |->
      periph_di_o[pin_mux_pkg::FN_CONVERTER_A_HIGH_REF] == $past(pad_in_i[18]))
    else $error("C2 reference route wrong");

  a_c4_cmp_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[19]) && $past(sel[39:38]) == 2'h1 |->
      periph_di_o[pin_mux_pkg::FN_COMPARATOR_B_INPUT_3] == $past(pad_in_i[19]))
    else $error("C4 comparator route wrong");

  a_c6_vref_route: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[21]) && $past(sel[43:42]) == 2'h1 |->
      periph_di_o[pin_mux_pkg::FN_CONVERTER_B_HIGH_REF] == $past(pad_in_i[21]))
    else $error("C6 reference route wrong");

  // Output routes
  a_b0_scl_drive: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[8]) && $past(sel[17:16]) == 2'h1 |->
      pad_oe_n_o[8] == !$past(periph_oe_i[pin_mux_pkg::FN_I2C_SCL]))
    else $error("B0 i2c clock enable wrong");

  a_b2_reload_drive: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[10]) && $past(sel[21:20]) == 2'h2 |->
      pad_do_o[10] == $past(periph_do_i[pin_mux_pkg::FN_PWM_RELOAD_SRC_0]))
    else $error("B2 reload level wrong");

  a_b3_mosi_drive: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[11]) && $past(sel[23:22]) == 2'h0 |->
      pad_do_o[11] == $past(periph_do_i[pin_mux_pkg::FN_SPI_MOSI]))
    else $error("B3 mosi level wrong");

  a_b4_clkout_drive: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[12]) && $past(sel[25:24]) == 2'h1 |->
      pad_do_o[12] == $past(periph_do_i[pin_mux_pkg::FN_CLOCK_OUTPUT]))
    else $error("B4 clock output level wrong");

  a_b7_tx_drive: assert property (@(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) && $past(periph_mode_o[15]) && $past(sel[31:30]) == 2'h0 |->
      (pad_do_o[15] == $past(periph_do_i[pin_mux_pkg::FN_SERIAL_TRANSMIT_DATA_0]))
      && (pad_oe_n_o[15] == !$past(periph_oe_i[pin_mux_pkg::FN_SERIAL_TRANSMIT_DATA_0])))
    else $error("B7 transmit drive wrong");

  // Further input routes
  a_a4_timer_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[4]
      && sel[9:8] == 2'h1) |->
    periph_di_o[pin_mux_pkg::FN_TIMER_CH_2] == $past(pad_in_i[4]))
    else $error("A4 timer route wrong");

  a_a6_fault_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[6]
      && sel[13:12] == 2'h0) |->
    periph_di_o[pin_mux_pkg::FN_FAULT_IN_0] == $past(pad_in_i[6]))
    else $error("A6 fault route wrong");

  a_a7_reset_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[7]
      && sel[15:14] == 2'h0) |->
    periph_di_o[pin_mux_pkg::FN_RESET_IN] == $past(pad_in_i[7]))
    else $error("A7 reset route wrong");

  a_b0_sclk_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[8]
      && sel[17:16] == 2'h0) |->
    periph_di_o[pin_mux_pkg::FN_SPI_CLOCK] == $past(pad_in_i[8]))
    else $error("B0 spi clock route wrong");

  a_b5_extclk_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && pll_ext_clk_en_i
      && periph_mode_o[13] && sel[27:26] == 2'h2) |->
    periph_di_o[pin_mux_pkg::FN_EXTERNAL_CLOCK_INPUT] == $past(pad_in_i[13]))
    else $error("B5 external clock route wrong");

  a_c2_analog_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[18]
      && sel[37:36] == 2'h0) |->
    periph_di_o[pin_mux_pkg::FN_ANALOG_INPUT_A2] == $past(pad_in_i[18]))
    else $error("C2 analog route wrong");

  a_d3_tms_route: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[25]
      && sel[51:50] == 2'h0) |->
    periph_di_o[pin_mux_pkg::FN_JTAG_TMS] == $past(pad_in_i[25]))
    else $error("D3 tms route wrong");

  // Drive and port input paths
  a_a5_pwm_drive: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i && periph_mode_o[5]
      && sel[11:10] == 2'h0) |->
    pad_do_o[5] == $past(periph_do_i[pin_mux_pkg::FN_PWM_OUT_5]))
    else $error("A5 pwm level wrong");

  a_gpio_di_path: assert property (
    @(posedge clock_i) disable iff (srst_i)
    $past(ce_i && !srst_i) |->
      gpio_di_o == $past(pad_in_i))
    else $error("port input not sampled");

endmodule : gpio_port_pin_mux

// ---- bench/board_model.sv ----
// Board-side model of each package pad: mux drive or the board's own level
module board_model (
  input  wire logic [25:0] pad_do_i,
  input  wire logic [25:0] pad_oe_n_i,
  input  wire logic [25:0] level_i,
  output logic      [25:0] pad_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A driven pad follows the mux, otherwise the board's pull level
  assign pad_in_o = (~pad_oe_n_i & pad_do_i) | (pad_oe_n_i & level_i);
endmodule : board_model

// ---- bench/testbench.sv ----
// Self-checking bench for the pin multiplexer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        cfg_wr_i = 1'b0;
  logic        cfg_periph_i = 1'b0;
  logic        pll_ext_clk_en_i = 1'b1;
  logic [4:0]  cfg_pin_i = 5'h00;
  logic [1:0]  cfg_sel_i = 2'h0;
  logic [25:0] gpio_do_i = 26'h0, gpio_dir_i = 26'h0, level = 26'h0;
  logic [25:0] pad_in_i, pad_do_o, pad_oe_n_o, periph_mode_o, gpio_di_o;
  logic [40:0] periph_do_i = 41'h0, periph_oe_i = 41'h0, periph_di_o;
  logic [51:0] peripheral_select_reg_o;
  int          errors = 0;
  int          n_compared = 0;
  // Routed choices as pin, select code, function code
  int map [33] = '{20'h04004, 20'h04108, 20'h0420B, 20'h05005, 20'h05109, 20'h0520C,
    20'h0600A, 20'h06106, 20'h0800F, 20'h08113, 20'h0A011, 20'h0A108, 20'h0A215,
    20'h0B012, 20'h0B109, 20'h0B216, 20'h0C006, 20'h0C118, 20'h0C217, 20'h0D007,
    20'h0D10D, 20'h0D219, 20'h0E01A, 20'h0E114, 20'h0E219, 20'h0F01B, 20'h0F113,
    20'h1201E, 20'h1211F, 20'h13020, 20'h13121, 20'h15023, 20'h15124};

  gpio_port_pin_mux uut (.clock_i(clock_i), .srst_i(srst_i), .ce_i(ce_i),
    .cfg_wr_i(cfg_wr_i), .cfg_pin_i(cfg_pin_i), .cfg_periph_i(cfg_periph_i),
    .cfg_sel_i(cfg_sel_i), .pll_ext_clk_en_i(pll_ext_clk_en_i), .gpio_do_i(gpio_do_i),
    .gpio_dir_i(gpio_dir_i), .periph_do_i(periph_do_i), .periph_oe_i(periph_oe_i),
    .pad_in_i(pad_in_i), .pad_do_o(pad_do_o), .pad_oe_n_o(pad_oe_n_o), .gpio_di_o(gpio_di_o),
    .periph_di_o(periph_di_o), .periph_mode_o(periph_mode_o),
    .peripheral_select_reg_o(peripheral_select_reg_o));
  board_model board (.pad_do_i(pad_do_o), .pad_oe_n_i(pad_oe_n_o), .level_i(level),
    .pad_in_o(pad_in_i));

  // 40 MHz clock
  always #12.5 clock_i = ~clock_i;

  task automatic cmp_bit(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic cmp_vec(string what, logic [63:0] exp, logic [63:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_vec

  // Lets outputs settle past the edge before looking
  task automatic wait_n(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : wait_n

  // One config write; ends on the edge that took it
  task automatic cfg(int pin, logic per, int sel);
    @(posedge clock_i);
    cfg_wr_i <= 1'b1;
    cfg_pin_i <= pin[4:0];
    cfg_periph_i <= per;
    cfg_sel_i <= sel[1:0];
    @(posedge clock_i);
    cfg_wr_i <= 1'b0;
  endtask : cfg

  task automatic report_and_stop;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    int p, s, f;
    repeat (16) @(posedge clock_i);
    srst_i <= 1'b0;
    #1;
    cmp_vec("mode", 64'(pin_mux_pkg::MODE_RST), 64'(periph_mode_o));
    cmp_vec("select", 64'h0, 64'(peripheral_select_reg_o));
    cmp_vec("periph_di", 64'(pin_mux_pkg::FN_IDLE), 64'(periph_di_o));
    cmp_vec("pad_oe_n", 64'h3FFFFFF, 64'(pad_oe_n_o));
    foreach (map[i]) begin
      p = map[i] >> 12;
      s = (map[i] >> 8) & 15;
      f = map[i] & 255;
      cfg(p, 1'b1, s);
      for (int v = 0; v < 2; v++) begin
        @(posedge clock_i);
        level[p] <= v[0];
        wait_n(3);
        cmp_bit("routed", v[0], periph_di_o[f]);
        cmp_bit("gpio_di", v[0], gpio_di_o[p]);
      end
      cmp_vec("sel", 64'(s), 64'(peripheral_select_reg_o[2*p+:2]));
      cmp_bit("mode", 1'b1, periph_mode_o[p]);
      cfg(p, 1'b0, 0);
      level[p] <= 1'b0;
    end
    // Writes with the clock enable low or past the last pin are dropped
    @(posedge clock_i);
    ce_i <= 1'b0;
    cfg(4, 1'b1, 1);
    ce_i <= 1'b1;
    cfg(26, 1'b1, 1);
    wait_n(1);
    cmp_vec("refused", 64'(pin_mux_pkg::MODE_RST), 64'(periph_mode_o));
    cfg(13, 1'b1, 2);
    pll_ext_clk_en_i <= 1'b0;
    level[13] <= 1'b1;
    wait_n(3);
    cmp_bit("ext clock", 1'b0, periph_di_o[25]);
    cfg(13, 1'b0, 0);
    pll_ext_clk_en_i <= 1'b1;
    gpio_dir_i[4] <= 1'b1;
    gpio_do_i[4] <= 1'b1;
    periph_oe_i <= '1;
    wait_n(3);
    cmp_bit("port oe_n", 1'b0, pad_oe_n_o[4]);
    cmp_bit("port level", 1'b1, pad_do_o[4]);
    @(posedge clock_i);
    gpio_dir_i[4] <= 1'b0;
    wait_n(3);
    cmp_bit("port released", 1'b1, pad_oe_n_o[4]);
    cfg(15, 1'b1, 0);
    periph_do_i <= '1;
    wait_n(3);
    cmp_bit("tx oe_n", 1'b0, pad_oe_n_o[15]);
    cmp_bit("tx level", 1'b1, pad_do_o[15]);
    cfg(8, 1'b1, 3);
    level[8] <= 1'b1;
    gpio_dir_i[8] <= 1'b1;
    wait_n(3);
    cmp_bit("spare oe_n", 1'b1, pad_oe_n_o[8]);
    cmp_bit("spare in", 1'b0, periph_di_o[15]);
    report_and_stop;
  end

  // Watchdog well past the expected run length
  initial begin
    repeat (4000) @(posedge clock_i);
    errors++;
    report_and_stop;
  end
endmodule : testbench
